// *** src/tws_pkg.sv ***
// Purpose: Shared constants and types for the two-wire slave interface
// Assumes: 50 MHz core clock
// Notes:   Times are kept in ns, cycle counts derived from them

// ****************************************************************
// Package
// ****************************************************************
package tws_pkg;
    localparam int          CLK_NS     = 20;    // Core clock period
    localparam int          FILT_NS    = 250;   // Least pulse seen as an edge
    localparam int          HOLD_NS    = 300;   // SCL fall region to bridge
    // Least times, rounded up to whole cycles
    localparam int          FILT_CYC   = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int          HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_WIDTH  = 5;     // Width of filter and hold counters
    localparam int          BYTE_W     = 8;     // Bits in a byte
    localparam int          PTR_WIDTH  = 8;     // Word-address pointer width
    localparam int          BUF_DEPTH  = 2;     // Write buffer entries
    localparam logic [7:0]  SLAVE_ADDR = 8'hD0; // Fixed slave address byte
    localparam logic [3:0]  BIT_LAST   = 4'h8;  // Bit count of a full byte
    localparam logic [3:0]  BIT_ONE    = 4'h1;  // Ack clock seen
    localparam logic [3:0]  BIT_NONE   = 4'h0;  // Count cleared
    localparam logic [7:0]  PTR_RESET  = 8'h00; // Pointer after reset or abort
    localparam logic        SYNC_RESET = 1'b0;  // Synchroniser reset level
    localparam logic        LINE_IDLE  = 1'b1;  // Released bus line level

    // Link states, Gray coded in the order listed
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_ACK    = 3'h3,
        ST_WORD   = 3'h2,
        ST_WDATA  = 3'h6,
        ST_RDATA  = 3'h7,
        ST_RACK   = 3'h5,
        ST_IGNORE = 3'h4
    } tws_state_type;
endpackage : tws_pkg

// *** src/tws_glitch_filter.sv ***
// Purpose: Synchronise a bus pin and reject short pulses
// Assumes: Pin is asynchronous to mclk_in and idles high
// Notes:   Output follows input only after FILT_C stable cycles

`timescale 1ns/10ps

module tws_glitch_filter import tws_pkg::*; #(
    parameter int CNT_W  = CNT_WIDTH,
    parameter int FILT_C = FILT_CYC
) (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic raw_in,
    output logic      filt_out
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic             s1_q;    // First synchroniser stage
    logic             s2_q;    // Second synchroniser stage
    logic             filt_q;  // Filtered level
    logic             filt_d;
    logic [CNT_W-1:0] cnt_q;   // Stable-cycle counter
    logic [CNT_W-1:0] cnt_d;

    // Count how long the new level has stood
    always_comb begin
        filt_d = filt_q;
        cnt_d  = '0;
        if (s2_q != filt_q) begin
            if (cnt_q == CNT_W'(FILT_C - 1)) begin
                filt_d = s2_q;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // Register stage
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q   <= LINE_IDLE;
            s2_q   <= LINE_IDLE;
            filt_q <= LINE_IDLE;
            cnt_q  <= '0;
        end else begin
            s1_q   <= raw_in;
            s2_q   <= s1_q;
            filt_q <= filt_d;
            cnt_q  <= cnt_d;
        end
    end

    assign filt_out = filt_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_filter_settle: assert property (@(posedge mclk_in) disable iff (rst_in)
        (filt_q != $past(filt_q)) |-> ($past(cnt_q) == CNT_W'(FILT_C - 1)))
        else $error("filtered level changed before settle count");
endmodule : tws_glitch_filter

// *** src/tws_pair_buf.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock domain
// Notes:   in_ready_out falls only when both entries are held

`timescale 1ns/10ps

module tws_pair_buf import tws_pkg::*; #(
    parameter int W     = BYTE_W + PTR_WIDTH,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [W-1:0] mem_q [DEPTH];  // Entry storage
    logic [W-1:0] mem_d [DEPTH];
    logic         wp_q;           // Write slot
    logic         wp_d;
    logic         rp_q;           // Read slot
    logic         rp_d;
    logic [1:0]   cnt_q;          // Entries held
    logic [1:0]   cnt_d;
    logic         push;
    logic         pop;

    assign in_ready_out  = (cnt_q != 2'(DEPTH));
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out  = mem_q[rp_q];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // Next entry state
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data_in;
            wp_d        = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    // Register stage
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : tws_pair_buf

// *** src/tws_slave.sv ***
// Purpose: Two-wire bus slave front end of a clock device
// Assumes: SCL and SDA are asynchronous pins; core clock 50 MHz
// Notes:   SDA is open drain: sda_oe_out high pulls the line low
//
// Notes on behaviour
// - SDA change during SCL high is control
// - Bus idle when SDA and SCL high
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - One bit per SCL pulse, change low
// - START opens, STOP closes, no byte limit
// - Eight-bit bytes plus ninth acknowledge slot
// - Acknowledge held low through ack clock high
// - Addressed receiver acknowledges every byte; code gives no ack to a data byte while the write buffer is full
// - On no-ack, release SDA, stop sending
// - Delay SDA change after SCL fall 300ns
// - Filter SDA and SCL pulses under 250ns
// - Answer only slave address D0h
// - Write: byte after address loads pointer
// - Advance pointer only on acknowledged byte
// - Supply low aborts, clears pointer, ignores bus

`timescale 1ns/10ps

module tws_slave import tws_pkg::*; #(
    parameter int PTR_W = PTR_WIDTH,
    parameter int CNT_W = CNT_WIDTH
) (
    input  wire logic             mclk_in,       // Core clock
    input  wire logic             rst_in,        // Async reset, active high
    input  wire logic             scl_in,        // Bus clock pin
    input  wire logic             sda_in,        // Bus data pin level
    output logic                  sda_out,       // Bus data drive value
    output logic                  sda_oe_out,    // Bus data pull-low enable
    input  wire logic             supply_low_in, // Supply under switchover
    output logic                  bus_idle_out,  // Bus seen idle
    output logic [PTR_W-1:0]      rd_addr_out,   // Word-address pointer
    input  wire logic [7:0]       rd_data_in,    // Byte at rd_addr_out
    output logic                  wr_valid_out,  // Written byte ready
    input  wire logic             wr_ready_in,   // Taker accepts byte
    output logic [PTR_W-1:0]      wr_addr_out,   // Written byte address
    output logic [7:0]            wr_data_out    // Written byte
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic                scl_f, sda_f;             // Filtered clock and data lines
    logic                scl_p_q, sda_p_q;         // Lines one cycle ago
    logic                sup1_q, sup2_q;           // Supply flag synchroniser stages
    logic                scl_rise, scl_fall, lo_ok; // Clock edges, low and hold elapsed
    logic                start_det, stop_det;      // START and STOP seen
    logic [CNT_W-1:0]    hold_q, hold_d;           // Hold delay counter
    tws_state_type       state_q, state_d;         // Link state
    tws_state_type       next_q, next_d;           // State after acknowledge
    logic [3:0]          cnt_q, cnt_d;             // Bit counter
    logic [7:0]          shift_q, shift_d;         // Received bits
    logic [7:0]          tx_q, tx_d;               // Byte being sent
    logic [PTR_W-1:0]    ptr_q, ptr_d;             // Word-address pointer
    logic                drv_q, drv_d;             // Pull SDA low
    logic                idle_q, idle_d;           // Bus idle flag
    logic                push_valid, push_ready;   // Byte offered, buffer has room

    // Pointer step, wraps at the top
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = p + 1'b1;
    endfunction : ptr_inc

    // ****************************************************************
    // Input conditioning
    // ****************************************************************
    // Clock line filter
    tws_glitch_filter #(
        .CNT_W    (CNT_W),
        .FILT_C   (FILT_CYC)
    ) u_scl_filt (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .raw_in   (scl_in),
        .filt_out (scl_f)
    );

    // Data line filter
    tws_glitch_filter #(
        .CNT_W    (CNT_W),
        .FILT_C   (FILT_CYC)
    ) u_sda_filt (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .raw_in   (sda_in),
        .filt_out (sda_f)
    );

    // Bus events
    assign scl_rise  = scl_f & ~scl_p_q;
    assign scl_fall  = ~scl_f & scl_p_q;
    assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    assign lo_ok     = ~scl_f & ~scl_p_q & (hold_q == '0);

    // Hold delay after each clock fall
    always_comb begin
        hold_d = hold_q;
        if (scl_fall) begin
            hold_d = CNT_W'(HOLD_CYC);
        end else if (hold_q != '0) begin
            hold_d = hold_q - 1'b1;
        end
    end

    // ****************************************************************
    // Link state machine
    // ****************************************************************
    always_comb begin
        state_d    = state_q;
        next_d     = next_q;
        cnt_d      = cnt_q;
        shift_d    = shift_q;
        tx_d       = tx_q;
        ptr_d      = ptr_q;
        drv_d      = drv_q;
        push_valid = 1'b0;
        idle_d     = scl_f & sda_f & (state_q == ST_IDLE);
        if (sup2_q) begin
            // Abort, clear pointer, ignore bus
            state_d = ST_IDLE;
            ptr_d   = PTR_RESET;
            cnt_d   = BIT_NONE;
            drv_d   = 1'b0;
            idle_d  = 1'b0;
        end else if (start_det) begin
            // Fresh or repeated START
            state_d = ST_ADDR;
            cnt_d   = BIT_NONE;
            drv_d   = 1'b0;
        end else if (stop_det) begin
            // End of transfer
            state_d = ST_IDLE;
            cnt_d   = BIT_NONE;
            drv_d   = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WORD, ST_WDATA: begin
                    if (scl_rise && cnt_q != BIT_LAST) begin
                        // Sample one bit per clock pulse
                        shift_d = {shift_q[6:0], sda_f};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (lo_ok && cnt_q == BIT_LAST) begin
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == SLAVE_ADDR[7:1]) begin
                                // Address match, acknowledge
                                state_d = ST_ACK;
                                drv_d   = 1'b1;
                                cnt_d   = BIT_NONE;
                                next_d  = shift_q[0] ? ST_RDATA : ST_WORD;
                            end else begin
                                // Not ours, stay off the bus
                                state_d = ST_IGNORE;
                                drv_d   = 1'b0;
                            end
                        end else if (state_q == ST_WORD) begin
                            // Word address into pointer
                            ptr_d   = shift_q[PTR_W-1:0];
                            state_d = ST_ACK;
                            drv_d   = 1'b1;
                            cnt_d   = BIT_NONE;
                            next_d  = ST_WDATA;
                        end else begin
                            // Data byte: wait for buffer room
                            push_valid = 1'b1;
                            if (push_ready) begin
                                ptr_d   = ptr_inc(ptr_q);
                                state_d = ST_ACK;
                                drv_d   = 1'b1;
                                cnt_d   = BIT_NONE;
                                next_d  = ST_WDATA;
                            end
                        end
                    end else if (lo_ok) begin
                        drv_d = 1'b0;  // Receiver keeps line free
                    end
                end
                ST_ACK: begin
                    if (scl_rise) begin
                        cnt_d = BIT_ONE;  // Ack clock taken
                    end else if (lo_ok && cnt_q == BIT_ONE) begin
                        // Ack slot over, after hold delay
                        state_d = next_q;
                        cnt_d   = BIT_NONE;
                        if (next_q == ST_RDATA) begin
                            tx_d  = rd_data_in;
                            drv_d = ~rd_data_in[7];
                        end else begin
                            drv_d = 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (lo_ok) begin
                        if (cnt_q == BIT_LAST) begin
                            // Byte sent, free line for ack
                            drv_d   = 1'b0;
                            state_d = ST_RACK;
                            cnt_d   = BIT_NONE;
                        end else begin
                            // Next bit, most significant first
                            drv_d = ~tx_q[3'h7 - cnt_q[2:0]];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (!sda_f) begin
                            // Master acknowledged
                            ptr_d = ptr_inc(ptr_q);
                            cnt_d = BIT_ONE;
                        end else begin
                            // No ack: stop sending
                            state_d = ST_IGNORE;
                        end
                    end else if (lo_ok && cnt_q == BIT_ONE) begin
                        state_d = ST_RDATA;
                        cnt_d   = BIT_NONE;
                        tx_d    = rd_data_in;
                        drv_d   = ~rd_data_in[7];
                    end
                end
                ST_IGNORE, ST_IDLE: begin
                    drv_d = 1'b0;  // Released until START or STOP
                end
                default: begin
                    state_d = ST_IDLE;
                    drv_d   = 1'b0;
                end
            endcase
        end
    end

    // Register stage, supply flag synchroniser included
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sup1_q  <= SYNC_RESET;
            sup2_q  <= SYNC_RESET;
            scl_p_q <= LINE_IDLE;
            sda_p_q <= LINE_IDLE;
            hold_q  <= '0;
            state_q <= ST_IDLE;
            next_q  <= ST_IDLE;
            cnt_q   <= BIT_NONE;
            shift_q <= 8'h00;
            tx_q    <= 8'h00;
            ptr_q   <= PTR_RESET;
            drv_q   <= 1'b0;
            idle_q  <= 1'b0;
        end else begin
            sup1_q  <= supply_low_in;
            sup2_q  <= sup1_q;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            hold_q  <= hold_d;
            state_q <= state_d;
            next_q  <= next_d;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            tx_q    <= tx_d;
            ptr_q   <= ptr_d;
            drv_q   <= drv_d;
            idle_q  <= idle_d;
        end
    end

    // ****************************************************************
    // Write buffer
    // ****************************************************************
    tws_pair_buf #(
        .W             (PTR_W + 8),
        .DEPTH         (BUF_DEPTH)
    ) u_wbuf (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (push_ready),
        .in_data_in    ({ptr_q, shift_q}),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  ({wr_addr_out, wr_data_out})
    );

    assign sda_out      = 1'b0;
    assign sda_oe_out   = drv_q;
    assign bus_idle_out = idle_q;
    assign rd_addr_out  = ptr_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_drive_low_only: assert property ($rose(sda_oe_out) |-> !scl_f)
        else $error("data drive started while clock high");
    a_hold_after_fall: assert property ($fell(scl_f) |=> (!$rose(sda_oe_out))[*8])
        else $error("data drive changed inside hold window");
    a_start_addr: assert property (start_det && !sup2_q |=>
        state_q == ST_ADDR && cnt_q == BIT_NONE)
        else $error("START did not restart address byte");
    a_stop_idle: assert property (stop_det && !sup2_q |=>
        state_q == ST_IDLE ##1 !sda_oe_out)
        else $error("STOP did not end transfer");
    a_idle_flag: assert property (state_q == ST_IDLE && scl_f && sda_f && !sup2_q
        |=> bus_idle_out)
        else $error("idle bus not flagged");
    a_ack_low: assert property (state_q == ST_ACK && scl_f |-> sda_oe_out)
        else $error("acknowledge not held low in clock high");
    a_addr_ignore: assert property (state_q == ST_IGNORE |-> !sda_oe_out)
        else $error("data driven after address mismatch");
    a_word_load: assert property (state_q == ST_WORD && cnt_q == BIT_LAST && lo_ok
        && !sup2_q |=> ptr_q == $past(shift_q))
        else $error("word address not loaded");
    a_ptr_adv: assert property (state_q == ST_RACK && scl_rise && !sda_f && !sup2_q
        |=> ptr_q == $past(ptr_q) + 1'b1)
        else $error("pointer not advanced on ack");
    a_nack_stop: assert property (state_q == ST_RACK && scl_rise && sda_f && !sup2_q
        |=> state_q == ST_IGNORE && !sda_oe_out)
        else $error("sending went on after no-ack");
    a_supply_abort: assert property (sup2_q |=>
        state_q == ST_IDLE && ptr_q == PTR_RESET && !sda_oe_out)
        else $error("supply drop did not abort");

    c_write_byte: cover property (push_valid && push_ready);
    c_read_ack: cover property (state_q == ST_RACK && scl_rise && !sda_f);
    c_read_nack: cover property (state_q == ST_RACK && scl_rise && sda_f);
    c_rep_start: cover property (start_det && state_q != ST_IDLE);
endmodule : tws_slave

// *** dv/tws_master_model.sv ***
// Purpose: Bus master model that drives SCL and pulls SDA low
// Assumes: Slow bus phases, so the slave filter sees every level
// Notes:   Released SDA reads high through the bench pull-up

`timescale 1ns/10ps

module tws_master_model (
    output logic      scl_out,  // Bus clock
    output logic      pull_out, // High pulls SDA low
    input  wire logic sda_in    // Wired SDA level
);
    localparam time PH = 1000; // Half bit time in ns

    // Idle bus at time zero
    initial begin
        scl_out  = 1'b1;
        pull_out = 1'b0;
    end

    // One bit: change mid-low, sample at end of high
    task automatic bit_x(input logic b, output logic s);
        #(PH / 2);
        pull_out = ~b;
        #(PH / 2);
        scl_out = 1'b1;
        #PH;
        s = sda_in;
        scl_out = 1'b0;
    endtask : bit_x

    // Byte MSB first, then acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                        output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ack_tx, ack_rx);
    endtask : xfer

    // Idle bus, or repeated START after an acknowledge slot
    task automatic start;
        #(PH / 2);
        pull_out = 1'b0;
        #(PH / 2);
        scl_out = 1'b1;
        #PH;
        pull_out = 1'b1;
        #PH;
        scl_out = 1'b0;
    endtask : start

    task automatic stop;
        #(PH / 2);
        pull_out = 1'b1;
        #(PH / 2);
        scl_out = 1'b1;
        #PH;
        pull_out = 1'b0;
        #(2 * PH);
    endtask : stop
endmodule : tws_master_model

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the two-wire slave
// Assumes: Master model runs slow bus phases
// Notes:   Written bytes are checked against an expected queue

`timescale 1ns/10ps

module tb import tws_pkg::*;;
    logic        mclk_in = 1'b0, rst_in = 1'b1, supply_low_in = 1'b0, wr_ready_in = 1'b0;
    logic        scl, pull, oe, so, idle, wv, a;
    logic [7:0]  ra, wa, wd, rx;
    logic [15:0] exp_q[$];                       // Expected {address,data}
    logic [31:0] seed = 32'h6C3456AD;
    int          miscompares = 0, checked = 0, cyc = 0;
    wire         sda = ~((oe & ~so) | pull);     // Open drain with pull-up

    initial forever #10 mclk_in = ~mclk_in;

    tws_slave uut (.mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(so), .sda_oe_out(oe), .supply_low_in(supply_low_in), .bus_idle_out(idle),
        .rd_addr_out(ra), .rd_data_in(ra ^ 8'h5A), .wr_valid_out(wv),
        .wr_ready_in(wr_ready_in), .wr_addr_out(wa), .wr_data_out(wd));
    tws_master_model m (.scl_out(scl), .pull_out(pull), .sda_in(sda));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    // Written-byte checker and watchdog
    always @(posedge mclk_in) begin
        if (wv && wr_ready_in) chk({wa, wd}, exp_q.pop_front());
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        repeat (10) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        repeat (40) @(posedge mclk_in);
        #1 chk(idle, 1'b1);
        m.start();
        m.xfer(SLAVE_ADDR, 1'b1, rx, a);
        chk(a, 1'b0);
        m.xfer(8'h05, 1'b1, rx, a);
        chk(a, 1'b0);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            exp_q.push_back({8'h05 + 8'(i), seed[7:0]});
            m.xfer(seed[7:0], 1'b1, rx, a);
            chk(a, 1'b0);
        end
        m.stop();
        repeat (40) @(posedge mclk_in);
        #1 chk(wv, 1'b1);
        chk(ra, 8'h07);
        wr_ready_in = 1'b1;
        m.start();
        m.xfer(SLAVE_ADDR | 8'h01, 1'b1, rx, a);
        chk(a, 1'b0);
        m.xfer(8'hFF, 1'b0, rx, a);
        chk(rx, 8'h07 ^ 8'h5A);
        m.xfer(8'hFF, 1'b1, rx, a);
        chk(rx, 8'h08 ^ 8'h5A);
        repeat (40) @(posedge mclk_in);
        #1 chk(oe, 1'b0);
        m.stop();
        chk(ra, 8'h08);
        m.start();
        m.xfer(8'hA0, 1'b1, rx, a);
        chk(a, 1'b1);
        m.stop();
        // Pointer write, then repeated START into a read
        m.start();
        m.xfer(SLAVE_ADDR, 1'b1, rx, a);
        m.xfer(8'h03, 1'b1, rx, a);
        m.start();
        m.xfer(SLAVE_ADDR | 8'h01, 1'b1, rx, a);
        chk(a, 1'b0);
        m.xfer(8'hFF, 1'b1, rx, a);
        chk(rx, 8'h03 ^ 8'h5A);
        m.stop();
        chk(ra, 8'h03);
        @(posedge mclk_in) #1 supply_low_in = 1'b1;
        repeat (20) @(posedge mclk_in);
        chk(ra, PTR_RESET);
        #1 supply_low_in = 1'b0;
        repeat (20) @(posedge mclk_in);
        chk(exp_q.size(), 16'h0000);
        stop_test();
    end
endmodule : tb
